// ### rtl/mcc_crc32_checker.v
// Functional notes
// - Commands are ignored while a calculation runs.
// - Secure device: external low-window access gets error.
// - CPU access unrestricted; internal window advised.
// - Internal-window command may cover any address.
// - External-window command uses forced seed, address, length.
// - Region select: 0 array, 1 EEPROM, 2-3 reserved.
// - External command presets checksum to all ones.
// - Reflected CRC32 polynomial 0xEDB88320.
// - Input words come from flash or system RAM.
`timescale 1ns/1ps
`include "mcc_defines.vh"

// Checksum engine over a word-aligned range.
// Registers mirror in an internal and an
// external window; the external one forces
// seed, start and length to fixed regions.
// One word is outstanding at a time and is
// folded in one cycle by a 32-stage chain:
// a long path, traded for two cycles a word.
// Sticky events feed one level interrupt.
// No clock enable; every flop runs each edge.

module mcc_crc32_checker #(
    parameter [31:0] ARRAY_BASE  = 32'h00000000, // Flash array start
    parameter [31:0] ARRAY_SIZE  = 32'h00008000, // Flash array bytes, EEPROM excluded
    parameter [31:0] EEPROM_BASE = 32'h00008000, // EEPROM emulation start
    parameter [31:0] EEPROM_SIZE = 32'h00000000  // EEPROM emulation bytes
) (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [13:0] paddr,
    input  wire [31:0] pwdata,
    input  wire        debug_access,
    input  wire        security_bit,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    output reg         mem_req,
    output reg  [31:0] mem_addr,
    input  wire [31:0] mem_rdata,
    input  wire        mem_ack,
    input  wire        mem_err,
    output reg         irq
);

    // Sequencer states
    // Code 2'b11 is unused and falls back to idle
    localparam [1:0] ST_IDLE  = 2'b00; // Waiting for a command
    localparam [1:0] ST_FETCH = 2'b01; // Word request outstanding
    localparam [1:0] ST_FOLD  = 2'b10; // Word captured, folding

    // Register file and walk state
    reg  [1:0]             state_q;       // Sequencer state
    reg  [1:0]             state_d;       // Next sequencer state
    reg  [31:0]            addr_q;        // Start address register
    reg  [31:0]            length_q;      // Length register
    reg  [31:0]            data_q;        // Seed / running checksum
    reg  [1:0]             region_q;      // Region select of the last write while idle
    reg  [`MCC_EVENT_W-1:0] events_q;     // Sticky event bits
    reg  [`MCC_EVENT_W-1:0] mask_q;       // Interrupt mask
    reg  [`MCC_EVENT_W-1:0] rd_snap_q;    // Events seen by a status read
    reg                    rd_status_q;   // Pending read is of status
    reg  [31:0]            cur_addr_q;    // Next word address
    reg  [31:0]            remain_q;      // Bytes left to fetch
    reg  [31:0]            word_q;        // Captured memory word
    wire [31:0]            fold_out;      // Checksum after this word
    wire                   secure;        // Synchronised security level

    // Security bit arrives from the memory controller's pin domain
    // A request in the few cycles after a change
    // is still judged on the old level
    mcc_sync u_sec_sync (
        .pclk       (pclk),
        .presetn    (presetn),
        .async_in   (security_bit),
        .sync_out_q (secure)
    );

    // One word folded per fetch
    // Works on data_q in place, no seed copy
    mcc_fold u_fold (
        .crc_in  (data_q),
        .data_in (word_q),
        .crc_out (fold_out)
    );

    // Bus decode of the setup cycle
    // The offset ignores paddr[13:8], so each
    // 0x100 block of the external window mirrors
    // the same registers; only debug requests to
    // the internal window are refused when secure
    wire       setup_ph  = psel & ~penable;               // Setup cycle
    wire       access_ok = psel & penable & pready;       // Completing edge
    wire       in_int    = (paddr < `MCC_INT_WINDOW_END); // Internal window
    wire       in_ext    = ~in_int & (paddr < `MCC_EXT_WINDOW_END);
    wire [7:0] reg_off   = paddr[7:0];                    // Offset in a window
    wire       sec_block = debug_access & secure & in_int;
    wire       addr_bad  = ~(in_int | in_ext);            // Beyond both windows
    wire       busy      = (state_q != ST_IDLE);

    // Transfer captured at the setup edge
    reg        wr_ext_q; // Pending write came through external window
    reg [7:0]  wr_off_q; // Pending write offset
    reg        wr_ok_q;  // Pending write is legal

    // APB answer: registered, one cycle after setup, no wait states
    // Read data is taken at the setup edge; the
    // status clear later drops only those bits
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready      <= 1'b0;
            pslverr     <= 1'b0;
            prdata      <= `MCC_RST_WORD;
            wr_ext_q    <= 1'b0;
            wr_off_q    <= 8'h00;
            wr_ok_q     <= 1'b0;
            rd_status_q <= 1'b0;
            rd_snap_q   <= `MCC_RST_EVENTS;
        end else begin
            // One-cycle pulse per transfer
            pready      <= setup_ph;
            // Refused: at or above 0x2000, or secured debug to the internal window
            pslverr     <= setup_ph & (sec_block | addr_bad);
            wr_ext_q    <= in_ext;
            wr_off_q    <= reg_off;
            // CPU and unsecured adapter access both windows freely
            wr_ok_q     <= setup_ph & pwrite & ~sec_block & ~addr_bad;
            rd_status_q <= setup_ph & ~pwrite & ~sec_block & ~addr_bad &
                           (reg_off == `MCC_OFF_STATUS);
            rd_snap_q   <= events_q;
            prdata      <= `MCC_RST_WORD;
            // Read data captured now; error answers read as zero
            if (setup_ph && !pwrite && !sec_block && !addr_bad) begin
                // Offsets compared in address order
                if (reg_off == `MCC_OFF_CTRL) begin
                    prdata <= {29'h0, region_q, 1'b0};
                end else if (reg_off == `MCC_OFF_STATUS) begin
                    prdata <= {28'h0, busy, events_q};
                end else if (reg_off == `MCC_OFF_IRQ_MASK) begin
                    prdata <= {29'h0, mask_q};
                end else if (reg_off == `MCC_OFF_ADDR) begin
                    prdata <= addr_q;
                end else if (reg_off == `MCC_OFF_LENGTH) begin
                    prdata <= length_q;
                end else if (reg_off == `MCC_OFF_DATA) begin
                    prdata <= data_q;
                end else begin
                    prdata <= `MCC_RST_WORD; // Unmapped reads zero
                end
            end
        end
    end

    // Write strobes on the completing edge
    // Range and seed hold still while busy, so a
    // late write cannot disturb the walk
    wire wr_fire   = access_ok & wr_ok_q;
    wire wr_ctrl   = wr_fire & (wr_off_q == `MCC_OFF_CTRL);
    wire wr_mask   = wr_fire & (wr_off_q == `MCC_OFF_IRQ_MASK);
    wire wr_addr   = wr_fire & (wr_off_q == `MCC_OFF_ADDR) & ~busy;
    wire wr_length = wr_fire & (wr_off_q == `MCC_OFF_LENGTH) & ~busy;
    wire wr_data   = wr_fire & (wr_off_q == `MCC_OFF_DATA) & ~busy;
    // Status read clears at its completing edge
    wire rd_clear  = access_ok & rd_status_q;

    // Start request; ignored outright while busy
    // No error flag either: a dropped start only
    // shows as a done bit that does not repeat
    wire       start_req = wr_ctrl & pwdata[`MCC_CTRL_START] & ~busy;
    wire [1:0] region_wr = pwdata[`MCC_CTRL_REGION_HI:`MCC_CTRL_REGION_LO];

    // Resolved command parameters
    reg [31:0] cmd_addr;  // Effective start address
    reg [31:0] cmd_len;   // Effective length in bytes
    reg [31:0] cmd_seed;  // Effective preset
    reg        cmd_bad;   // Reserved region selected

    // Internal commands use software values, external ones forced values
    // Low address bits are cut, so a misaligned
    // value still walks whole words
    // A reserved region only raises command error
    always @* begin
        // Internal window: software range and seed
        cmd_addr = {addr_q[31:2], 2'b00};
        cmd_len  = {length_q[31:2], 2'b00};
        cmd_seed = data_q;
        cmd_bad  = 1'b0;
        // External window: forced values
        if (wr_ext_q) begin
            cmd_seed = `MCC_CRC_FIXED_SEED;
            if (region_wr == `MCC_REGION_ARRAY) begin
                cmd_addr = ARRAY_BASE;
                cmd_len  = ARRAY_SIZE;
            end else if (region_wr == `MCC_REGION_EEPROM) begin
                cmd_addr = EEPROM_BASE;
                cmd_len  = EEPROM_SIZE;
            end else begin
                cmd_bad  = 1'b1;
            end
        end
    end

    // Zero length completes at once, seed kept
    wire launch = start_req & ~cmd_bad;         // Accepted command
    wire empty  = (cmd_len[31:2] == 30'h0);     // Nothing to fetch
    // Internal lengths are cut to whole words, so
    // their count always reaches four exactly
    wire last   = (remain_q == `MCC_WORD_BYTES); // Final word in flight

    // Sequencer transitions
    // A memory error ends the run; the partial
    // value stays readable for diagnosis
    always @* begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                // Empty runs never leave idle
                if (launch && !empty) begin
                    state_d = ST_FETCH;
                end
            end
            ST_FETCH: begin
                // Wait for the memory answer
                if (mem_err) begin
                    state_d = ST_IDLE;
                end else if (mem_ack) begin
                    state_d = ST_FOLD;
                end
            end
            ST_FOLD: begin
                // Fold, then next word or idle
                state_d = last ? ST_IDLE : ST_FETCH;
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    // Event sources this cycle
    // Done rises on every way out of a run, so
    // a poller never hangs after a bus error
    wire ev_done   = (launch & empty) |
                     ((state_q == ST_FOLD) & last) |
                     ((state_q == ST_FETCH) & mem_err);
    wire ev_buserr = (state_q == ST_FETCH) & mem_err;
    wire ev_cmderr = start_req & cmd_bad;
    wire [`MCC_EVENT_W-1:0] ev_set = {ev_cmderr, ev_buserr, ev_done};

    // Sequencer, memory port and register storage
    // The request drops for one cycle between
    // words: the fold cycle, one word in flight
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q    <= ST_IDLE;
            addr_q     <= `MCC_RST_WORD;
            length_q   <= `MCC_RST_WORD;
            data_q     <= `MCC_RST_WORD;
            region_q   <= `MCC_RST_REGION;
            mask_q     <= `MCC_RST_EVENTS;
            cur_addr_q <= `MCC_RST_WORD;
            remain_q   <= `MCC_RST_WORD;
            word_q     <= `MCC_RST_WORD;
            mem_req    <= 1'b0;
            mem_addr   <= `MCC_RST_WORD;
        end else begin
            // Advance the sequencer
            state_q <= state_d;
            // Range registers, frozen while a command runs; mask always writable
            if (wr_addr) begin
                addr_q <= pwdata;
            end
            if (wr_length) begin
                length_q <= pwdata;
            end
            if (wr_mask) begin
                mask_q <= pwdata[`MCC_EVENT_W-1:0];
            end
            // Region kept for read-back
            if (wr_ctrl && !busy) begin
                region_q <= region_wr;
            end
            // Launch: preset checksum and walk pointers
            if (launch) begin
                data_q     <= cmd_seed;
                cur_addr_q <= cmd_addr;
                remain_q   <= cmd_len;
                mem_req    <= ~empty;
                mem_addr   <= cmd_addr;
            end else if (wr_data) begin
                data_q <= pwdata;
            end
            // One word per request, request drops on answer
            if (state_q == ST_FETCH && (mem_ack || mem_err)) begin
                mem_req <= 1'b0;
                // Word taken even on error; then unused
                word_q  <= mem_rdata;
            end
            // Fold, then step to the next ascending word
            if (state_q == ST_FOLD) begin
                data_q     <= fold_out;
                cur_addr_q <= cur_addr_q + `MCC_WORD_BYTES;
                remain_q   <= remain_q - `MCC_WORD_BYTES;
                mem_addr   <= cur_addr_q + `MCC_WORD_BYTES;
                mem_req    <= ~last;
            end
        end
    end

    // Sticky events: a new event wins over a read clear
    // so a completion is never lost to a poll
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            // No event pending after reset
            events_q <= `MCC_RST_EVENTS;
        end else begin
            // Only bits the read actually returned are cleared
            events_q <= (events_q & ~(rd_clear ? rd_snap_q : `MCC_RST_EVENTS))
                        | ev_set;
        end
    end

    // Level interrupt from masked sticky bits
    // Built from the next sticky value, so the
    // pin moves with the status register
    // Masked bits still show in status
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            // Quiet pin during reset
            irq <= 1'b0;
        end else begin
            irq <= |(((events_q & ~(rd_clear ? rd_snap_q : `MCC_RST_EVENTS))
                       | ev_set) & mask_q);
        end
    end

endmodule // mcc_crc32_checker

// ### rtl/mcc_defines.vh
`ifndef MCC_DEFINES_VH
`define MCC_DEFINES_VH

// Register offsets inside one window (byte addresses)
`define MCC_OFF_CTRL        8'h00
`define MCC_OFF_STATUS      8'h04
`define MCC_OFF_IRQ_MASK    8'h08
`define MCC_OFF_ADDR        8'h0C
`define MCC_OFF_LENGTH      8'h10
`define MCC_OFF_DATA        8'h14

// Control register fields
`define MCC_CTRL_START      0
`define MCC_CTRL_REGION_LO  1
`define MCC_CTRL_REGION_HI  2

// Status register fields (low three are sticky events)
`define MCC_ST_DONE         0
`define MCC_ST_BUSERR       1
`define MCC_ST_CMDERR       2
`define MCC_ST_BUSY         3
`define MCC_EVENT_W         3

// Region select codes for restricted commands
`define MCC_REGION_ARRAY    2'h0
`define MCC_REGION_EEPROM   2'h1

// Address windows of the block
`define MCC_INT_WINDOW_END  14'h0100
`define MCC_EXT_WINDOW_END  14'h2000

// Checksum constants
`define MCC_CRC_POLY        32'hEDB88320
`define MCC_CRC_FIXED_SEED  32'hFFFFFFFF
`define MCC_WORD_BYTES      32'h00000004

// Reset values
`define MCC_RST_WORD        32'h00000000
`define MCC_RST_EVENTS      3'h0
`define MCC_RST_REGION      2'h0

`endif

// ### rtl/mcc_sync.v
`timescale 1ns/1ps
`include "mcc_defines.vh"

module mcc_sync (
    input  wire pclk,
    input  wire presetn,
    input  wire async_in,
    output reg  sync_out_q
);

    reg s1_q; // First stage, read only by s2_q
    reg s2_q; // Second stage
    reg s3_q; // Third stage

    // Three-stage chain; a change is taken once stages two and three agree
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_q       <= 1'b0;
            s2_q       <= 1'b0;
            s3_q       <= 1'b0;
            sync_out_q <= 1'b0;
        end else begin
            s1_q <= async_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            // Hold last agreed level while stages disagree
            if (s2_q == s3_q) begin
                sync_out_q <= s3_q;
            end
        end
    end

endmodule // mcc_sync

// ### rtl/mcc_fold.v
`timescale 1ns/1ps
`include "mcc_defines.vh"

module mcc_fold (
    input  wire [31:0] crc_in,
    input  wire [31:0] data_in,
    output wire [31:0] crc_out
);

    wire [31:0] stage [0:32]; // Running value after each bit

    assign stage[0] = crc_in;

    // Reflected shift, bit 0 of the word enters first
    genvar i;
    generate
        for (i = 0; i < 32; i = i + 1) begin : g_bit
            assign stage[i+1] = (stage[i][0] ^ data_in[i]) ?
                                ((stage[i] >> 1) ^ `MCC_CRC_POLY) :
                                (stage[i] >> 1);
        end
    endgenerate

    assign crc_out = stage[32];

endmodule // mcc_fold

// ### testbench/mcc_checker.sv
`timescale 1ns/1ps
// Port-level watcher of the checksum block
module mcc_chk (
    input wire        pclk,
    input wire        presetn,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [13:0] paddr,
    input wire [31:0] pwdata,
    input wire        debug_access,
    input wire        security_bit,
    input wire [31:0] prdata,
    input wire        pready,
    input wire        pslverr,
    input wire        mem_req,
    input wire [31:0] mem_addr,
    input wire [31:0] mem_rdata,
    input wire        mem_ack,
    input wire        mem_err,
    input wire        irq
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire setup = psel && !penable; // Setup phase of a transfer
    a_setup_ready: assert property (setup |=> pready)
        else $error("no ready after setup");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    a_top_range: assert property (setup && paddr >= 14'h2000 |=> pslverr)
        else $error("no error above the windows");
    a_cpu_free: assert property (setup && !debug_access && paddr < 14'h2000 |=> !pslverr)
        else $error("cpu access refused");
    // Six cycles covers the pin synchroniser latency
    a_secure_low: assert property (security_bit [*6] ##0 (setup && debug_access
        && paddr < 14'h0100) |=> pslverr && prdata == 32'h0)
        else $error("secure low access not refused");
    a_mem_hold: assert property (mem_req && !mem_ack && !mem_err
        |=> mem_req && $stable(mem_addr))
        else $error("memory request dropped or moved");
    a_mem_step: assert property (mem_req && mem_ack |=> !mem_req ##1
        (!mem_req || mem_addr == $past(mem_addr, 2) + 32'h4))
        else $error("word address not ascending by four");
    a_err_abort: assert property (mem_req && mem_err |=> !mem_req [*3])
        else $error("run continued after memory error");
    c_mem_err: cover property (mem_req && mem_err);
    c_refused: cover property (pslverr);
    c_irq: cover property ($rose(irq));
endmodule // mcc_chk

bind mcc_crc32_checker mcc_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .debug_access(debug_access), .security_bit(security_bit), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .mem_req(mem_req), .mem_addr(mem_addr),
    .mem_rdata(mem_rdata), .mem_ack(mem_ack), .mem_err(mem_err), .irq(irq));

// ### testbench/mcc_mem_model.sv
`timescale 1ns/1ps
// Word memory behind the engine with a settable answer delay
module mcc_mem_model (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        mem_req,
    input  wire [31:0] mem_addr,
    input  wire [3:0]  lat,
    input  wire [31:0] err_addr,
    output reg  [31:0] mem_rdata,
    output reg         mem_ack,
    output reg         mem_err
);
    reg [3:0] cnt_q; // Cycles waited on this request
    // One answer per request; data wanders outside it so stale words never match
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q     <= 4'h0;
            mem_ack   <= 1'b0;
            mem_err   <= 1'b0;
            mem_rdata <= 32'h00000000;
        end else begin
            mem_ack   <= 1'b0;
            mem_err   <= 1'b0;
            mem_rdata <= ~mem_rdata;
            if (mem_req && !mem_ack && !mem_err) begin
                if (cnt_q < lat) begin
                    cnt_q <= cnt_q + 4'h1;
                end else begin
                    cnt_q     <= 4'h0;
                    mem_err   <= (mem_addr == err_addr);
                    mem_ack   <= (mem_addr != err_addr);
                    mem_rdata <= mem_addr ^ 32'h5A5A0F0F;
                end
            end
        end
    end
endmodule // mcc_mem_model

// ### testbench/tb_top.sv
`timescale 1ns/1ps
`include "mcc_defines.vh"
module tb_top;
    reg         pclk;
    reg         presetn;
    reg         psel;
    reg         penable;
    reg         pwrite;
    reg  [13:0] paddr;
    reg  [31:0] pwdata;
    reg         debug_access;
    reg         security_bit;
    reg  [3:0]  lat;      // Memory answer delay
    reg  [31:0] err_addr; // Word that answers with an error
    wire [31:0] prdata;
    wire        pready;
    wire        pslverr;
    wire        mem_req;
    wire [31:0] mem_addr;
    wire [31:0] mem_rdata;
    wire        mem_ack;
    wire        mem_err;
    wire        irq;
    reg  [31:0] rd;       // Data of the last transfer
    reg         er;       // Error of the last transfer
    reg  [31:0] want;     // Expected checksum
    integer     errors;
    integer     comparisons;
    integer     cycles;
    integer     r;

    mcc_crc32_checker #(.ARRAY_BASE(32'h00000100), .ARRAY_SIZE(32'h0000000C),
        .EEPROM_BASE(32'h00000200), .EEPROM_SIZE(32'h00000008)) DUT (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .debug_access(debug_access),
        .security_bit(security_bit), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .mem_req(mem_req), .mem_addr(mem_addr), .mem_rdata(mem_rdata), .mem_ack(mem_ack),
        .mem_err(mem_err), .irq(irq));
    mcc_mem_model u_mem (.pclk(pclk), .presetn(presetn), .mem_req(mem_req),
        .mem_addr(mem_addr), .lat(lat), .err_addr(err_addr), .mem_rdata(mem_rdata),
        .mem_ack(mem_ack), .mem_err(mem_err));

    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    // Hang guard, far above the few hundred cycles the tests need
    always @(posedge pclk) begin
        cycles = cycles + 1;
        if (cycles == 20000) begin
            errors = errors + 1;
            test_done;
        end
    end
    // One transfer; held until ready is seen at an edge
    task apb(input [13:0] a, input w, input [31:0] d, input dbg);
        begin
            @(posedge pclk);
            psel <= 1'b1;
            paddr <= a;
            pwrite <= w;
            pwdata <= d;
            debug_access <= dbg;
            @(posedge pclk);
            penable <= 1'b1;
            @(posedge pclk);
            while (pready !== 1'b1) @(posedge pclk);
            rd = prdata;
            er = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask
    // Window select doubles as the debug source flag
    task wr(input [7:0] o, input [31:0] d, input ext);
        apb({5'h00, ext, o}, 1'b1, d, ext);
    endtask
    task chk(input [79:0] nm, input [31:0] e, input [31:0] g);
        begin
            comparisons = comparisons + 1;
            if (g !== e) begin
                errors = errors + 1;
                $display("wrong value %0s expected %h seen %h", nm, e, g);
            end
        end
    endtask
    task rchk(input [79:0] nm, input [7:0] o, input ext, input [31:0] e);
        begin
            apb({5'h00, ext, o}, 1'b0, 32'h0, ext);
            chk(nm, e, rd);
        end
    endtask
    // Polls status; the read that shows completion also clears it
    task wait_done;
        begin
            rd = 32'h0;
            while (rd[0] !== 1'b1) apb({6'h00, `MCC_OFF_STATUS}, 1'b0, 32'h0, 1'b0);
        end
    endtask
    // Reflected checksum over the model's word pattern, no final inversion
    function [31:0] crc(input [31:0] c, input [31:0] a, input [31:0] n);
        integer w;
        integer i;
        reg [31:0] d;
        begin
            for (w = 0; w < n; w = w + 4) begin
                d = (a + w) ^ 32'h5A5A0F0F;
                for (i = 0; i < 32; i = i + 1)
                    c = (c[0] ^ d[i]) ? ((c >> 1) ^ `MCC_CRC_POLY) : (c >> 1);
            end
            crc = c;
        end
    endfunction
    task test_done;
        begin
            $display("comparisons %0d errors %0d", comparisons, errors);
            if (errors == 0 && comparisons > 0) begin
                $display("Test passed");
            end else begin
                $display("Test failed");
            end
            $finish;
        end
    endtask

    initial begin
        {presetn, psel, penable, pwrite, debug_access, security_bit} = 6'h00;
        paddr = 14'h0000;
        pwdata = 32'h0;
        lat = 4'h0;
        err_addr = 32'hFFFFFFFC;
        errors = 0;
        comparisons = 0;
        cycles = 0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rchk("status", `MCC_OFF_STATUS, 1'b0, 32'h0);
        chk("irq", 32'h0, {31'h0, irq});
        $display("test reset done");
        wr(`MCC_OFF_DATA, 32'h12345678, 1'b0);
        wr(`MCC_OFF_ADDR, 32'h00001000, 1'b0);
        wr(`MCC_OFF_LENGTH, 32'h00000010, 1'b0);
        wr(`MCC_OFF_IRQ_MASK, 32'h1, 1'b0);
        wr(`MCC_OFF_CTRL, 32'h1, 1'b0);
        while (irq !== 1'b1) @(posedge pclk);
        rchk("status", `MCC_OFF_STATUS, 1'b0, 32'h1);
        repeat (2) @(posedge pclk);
        chk("irq", 32'h0, {31'h0, irq});
        want = crc(32'h12345678, 32'h1000, 32'h10);
        rchk("sum", `MCC_OFF_DATA, 1'b0, want);
        $display("test internal done");
        lat <= 4'h5;
        wr(`MCC_OFF_ADDR, 32'h00002000, 1'b0);
        wr(`MCC_OFF_LENGTH, 32'h00000008, 1'b0);
        wr(`MCC_OFF_CTRL, 32'h1, 1'b0);
        wr(`MCC_OFF_ADDR, 32'h00003000, 1'b0);
        wr(`MCC_OFF_CTRL, 32'h1, 1'b0);
        wait_done;
        rchk("addr", `MCC_OFF_ADDR, 1'b0, 32'h00002000);
        want = crc(want, 32'h2000, 32'h8);
        rchk("sum", `MCC_OFF_DATA, 1'b0, want);
        rchk("status", `MCC_OFF_STATUS, 1'b0, 32'h0);
        $display("test busy done");
        lat <= 4'h0;
        for (r = 0; r < 4; r = r + 1) begin
            wr(`MCC_OFF_CTRL, r * 2 + 1, 1'b1);
            if (r < 2) begin
                wait_done;
                want = crc(32'hFFFFFFFF, r ? 32'h200 : 32'h100, r ? 32'h8 : 32'hC);
                rchk("forced", `MCC_OFF_DATA, 1'b1, want);
            end else begin
                rchk("cmderr", `MCC_OFF_STATUS, 1'b1, 32'h4);
            end
        end
        rchk("region", `MCC_OFF_CTRL, 1'b0, 32'h6);
        $display("test external done");
        security_bit <= 1'b1;
        repeat (6) @(posedge pclk);
        apb(14'h0004, 1'b0, 32'h0, 1'b1);
        chk("sec err", 32'h1, {31'h0, er});
        chk("sec data", 32'h0, rd);
        apb(14'h000C, 1'b1, 32'h00004000, 1'b1);
        rchk("addr", `MCC_OFF_ADDR, 1'b0, 32'h00002000);
        chk("cpu err", 32'h0, {31'h0, er});
        rchk("ext addr", `MCC_OFF_ADDR, 1'b1, 32'h00002000);
        chk("ext err", 32'h0, {31'h0, er});
        apb(14'h2000, 1'b0, 32'h0, 1'b0);
        chk("range err", 32'h1, {31'h0, er});
        security_bit <= 1'b0;
        $display("test security done");
        wr(`MCC_OFF_IRQ_MASK, 32'h0, 1'b0);
        wr(`MCC_OFF_DATA, 32'hCAFEF00D, 1'b0);
        wr(`MCC_OFF_LENGTH, 32'h0, 1'b0);
        wr(`MCC_OFF_CTRL, 32'h1, 1'b0);
        repeat (3) @(posedge pclk);
        chk("irq", 32'h0, {31'h0, irq});
        rchk("status", `MCC_OFF_STATUS, 1'b0, 32'h1);
        rchk("sum", `MCC_OFF_DATA, 1'b0, 32'hCAFEF00D);
        $display("test empty done");
        err_addr <= 32'h00001008;
        wr(`MCC_OFF_ADDR, 32'h00001000, 1'b0);
        wr(`MCC_OFF_LENGTH, 32'h00000010, 1'b0);
        wr(`MCC_OFF_CTRL, 32'h1, 1'b0);
        wait_done;
        chk("buserr", 32'h3, rd & 32'h7);
        $display("test bus error done");
        test_done;
    end
endmodule // tb_top
